// *** hw/vcm_pkg.sv ***
// Constants, register map and helper function of the video clock frequency meter.
// Assumes a 32-bit classic Wishbone register bus and a bus clock of 200 MHz.
`default_nettype none

package vcm_pkg;

	// ************************************************************
	// Bus geometry and register map.
	// ************************************************************
	localparam int unsigned VCM_DW             = 32;
	localparam int unsigned VCM_AW             = 8;
	localparam logic [7:0]  VCM_ADR_CTRL       = 8'h00;
	localparam logic [7:0]  VCM_ADR_DURATION   = 8'h04;
	localparam logic [7:0]  VCM_ADR_COUNT      = 8'h08;
	localparam logic [7:0]  VCM_ADR_STATUS     = 8'h0C;
	localparam logic [31:0] VCM_UNMAPPED_DATA  = 32'h0000_0000;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int unsigned VCM_CTRL_EN_BIT    = 0;
	localparam int unsigned VCM_STAT_RUN_BIT   = 0;
	localparam int unsigned VCM_STAT_FRESH_BIT = 1;
	localparam int unsigned VCM_STAT_NOCLK_BIT = 2;
	localparam int unsigned VCM_STAT_BUSY_BIT  = 3;

	// ************************************************************
	// Reset values and timing.
	// ************************************************************
	localparam logic        VCM_CTRL_EN_RST    = 1'b0;
	localparam logic [31:0] VCM_COUNT_RST      = 32'h0000_0000;
	localparam longint      VCM_CLK_HZ         = 200_000_000;
	localparam longint      VCM_WINDOW_US      = 1000;
	localparam logic [31:0] VCM_DURATION_RST   = 32'(VCM_CLK_HZ / 1_000_000 * VCM_WINDOW_US);

	// Merges write data into an old register value under the byte enables.
	function automatic logic [31:0] vcm_merge(input logic [31:0] old_v,
	                                          input logic [31:0] new_v,
	                                          input logic [3:0]  sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : vcm_merge

endpackage : vcm_pkg

`default_nettype wire

// *** hw/vcm_sync.sv ***
// Two flip-flop level synchroniser for one bit.
// Assumes the input is a level that stays put for at least two destination clock edges.
`timescale 1ns/1ps
`default_nettype none

module vcm_sync (
	input  wire logic clk_i,  // Destination clock.
	input  wire logic d_i,    // Level from the other domain.
	output var  logic q_o     // Synchronised level.
);

	logic meta_r;

	// No reset here: the first stage must only feed the second stage.
	always_ff @(posedge clk_i) begin
		meta_r <= d_i;
		q_o    <= meta_r;
	end

endmodule : vcm_sync

`default_nettype wire

// *** hw/vcm_meter.sv ***
// Video clock frequency meter with a classic Wishbone register slave.
// Assumes clk_i is the 200 MHz bus clock and vid_clk_i the video clock under test, which may stop.
//
// Behaviour
// - Sampling counter runs on the bus clock, cycle counter on the video clock.
// - Neither counter advances until software sets the enable bit.
// - The duration register gives the window length in bus clock cycles.
// - At the terminal count of the sampling counter one load pulse is issued.
// - Each load that finds no handshake open starts one; its answer copies the held cycle count into the readable count register.
// - The sampling counter clears at each load, the cycle counter at each capture; both repeat until enable is cleared.
// - Control, duration and count registers are reached over the register bus slave.
`timescale 1ns/1ps
`default_nettype none

module vcm_meter
	import vcm_pkg::*;
#(
	parameter logic [31:0] DURATION_RST = VCM_DURATION_RST  // Window length after reset.
) (
	input  wire logic              clk_i,      // Bus clock, 200 MHz.
	input  wire logic              rst_i,      // Synchronous reset, active high.
	input  wire logic              vid_clk_i,  // Video clock being measured.
	input  wire logic              wb_cyc_i,   // Wishbone cycle.
	input  wire logic              wb_stb_i,   // Wishbone strobe.
	input  wire logic              wb_we_i,    // Wishbone write enable.
	input  wire logic [VCM_AW-1:0] wb_adr_i,   // Wishbone byte address.
	input  wire logic [3:0]        wb_sel_i,   // Wishbone byte enables.
	input  wire logic [VCM_DW-1:0] wb_dat_i,   // Wishbone write data.
	output var  logic [VCM_DW-1:0] wb_dat_o,   // Wishbone read data.
	output var  logic              wb_ack_o    // Wishbone acknowledge.
);

	// ************************************************************
	// Bus clock domain state.
	// ************************************************************
	logic        en_r;
	logic [31:0] dur_r;
	logic [31:0] samp_cnt_r;
	logic [31:0] count_r;
	logic        req_tgl_r;
	logic        busy_r;
	logic        fresh_r;
	logic        noclk_r;

	logic        en_nxt;
	logic [31:0] dur_nxt;
	logic [31:0] samp_cnt_nxt;
	logic [31:0] count_nxt;
	logic        req_tgl_nxt;
	logic        fresh_nxt;
	logic        noclk_nxt;
	logic        busy_nxt;
	logic [31:0] rd_mux;

	// ************************************************************
	// Video clock domain state.
	// ************************************************************
	logic        vrst_s;
	logic        ven_s;
	logic        vreq_s;
	logic        vack_tgl_r;
	logic [31:0] vcnt_r;
	logic [31:0] vhold_r;
	logic        vcap;
	logic [31:0] vcnt_nxt;

	logic        ack_s;

	// ************************************************************
	// Crossings.
	// ************************************************************
	vcm_sync u_sync_vrst (
		.clk_i (vid_clk_i),
		.d_i   (rst_i),
		.q_o   (vrst_s)
	);

	vcm_sync u_sync_ven (
		.clk_i (vid_clk_i),
		.d_i   (en_r),
		.q_o   (ven_s)
	);

	vcm_sync u_sync_vreq (
		.clk_i (vid_clk_i),
		.d_i   (req_tgl_r),
		.q_o   (vreq_s)
	);

	vcm_sync u_sync_ack (
		.clk_i (clk_i),
		.d_i   (vack_tgl_r),
		.q_o   (ack_s)
	);

	// ************************************************************
	// Register bus decode.
	// ************************************************************
	wire acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr       = acc & wb_we_i;
	wire sel_ctrl = (wb_adr_i == VCM_ADR_CTRL);
	wire sel_dur  = (wb_adr_i == VCM_ADR_DURATION);
	wire sel_cnt  = (wb_adr_i == VCM_ADR_COUNT);
	wire sel_stat = (wb_adr_i == VCM_ADR_STATUS);

	wire [31:0] ctrl_word = {31'h0000_0000, en_r};
	wire [31:0] wr_ctrl   = vcm_merge(ctrl_word, wb_dat_i, wb_sel_i);
	wire [31:0] wr_stat   = vcm_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

	// The video toggle is undefined until the video clock has run through reset; gating the
	// compare with the bus side open flag keeps that out of the bus registers.
	wire        busy      = busy_r;
	wire        ack_edge  = busy_r & (ack_s == req_tgl_r);

	assign rd_mux = sel_ctrl ? ctrl_word :
	                sel_dur  ? dur_r :
	                sel_cnt  ? count_r :
	                sel_stat ? {28'h000_0000, busy, noclk_r, fresh_r, en_r} :
	                VCM_UNMAPPED_DATA;

	assign en_nxt  = (wr && sel_ctrl) ? wr_ctrl[VCM_CTRL_EN_BIT] : en_r;
	assign dur_nxt = (wr && sel_dur) ? vcm_merge(dur_r, wb_dat_i, wb_sel_i) : dur_r;

	// ************************************************************
	// Sampling counter.
	// ************************************************************
	// A duration of zero or one gives a load on every cycle.
	wire load = en_r && ({1'b0, samp_cnt_r} + 33'h0_0000_0001 >= {1'b0, dur_r});

	assign samp_cnt_nxt = (!en_r || load) ? 32'h0000_0000 : samp_cnt_r + 32'h0000_0001;

	// A load that finds the previous handshake still open means the video clock did not
	// answer within a whole window; the count then reads zero instead of going stale.
	assign req_tgl_nxt = req_tgl_r ^ (load & ~busy);
	assign count_nxt   = ack_edge      ? vhold_r :
	                     (load & busy) ? VCM_COUNT_RST :
	                     count_r;
	assign noclk_nxt   = ack_edge ? 1'b0 : ((load & busy) ? 1'b1 : noclk_r);
	assign fresh_nxt   = ack_edge | (fresh_r & ~(wr && sel_stat && wr_stat[VCM_STAT_FRESH_BIT]));
	assign busy_nxt    = (load & ~busy) | (busy & ~ack_edge);

	// ************************************************************
	// Registers of the bus clock domain.
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_r  <= VCM_CTRL_EN_RST;
			dur_r <= DURATION_RST;
		end else begin
			en_r  <= en_nxt;
			dur_r <= dur_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			samp_cnt_r <= 32'h0000_0000;
		end else begin
			samp_cnt_r <= samp_cnt_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_tgl_r <= 1'b0;
			busy_r    <= 1'b0;
		end else begin
			req_tgl_r <= req_tgl_nxt;
			busy_r    <= busy_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= VCM_COUNT_RST;
			fresh_r <= 1'b0;
			noclk_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			fresh_r <= fresh_nxt;
			noclk_r <= noclk_nxt;
		end
	end

	// Acknowledge and read data are registered so both leave the block from flip-flops.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= acc ? rd_mux : 32'h0000_0000;
		end
	end

	// ************************************************************
	// Cycle counter on the video clock.
	// ************************************************************
	// The hold register is written on the same edge the acknowledge toggles, so it has
	// been stable for two bus clock edges by the time the bus side samples it.
	assign vcap     = vreq_s ^ vack_tgl_r;
	assign vcnt_nxt = (!ven_s || vcap) ? 32'h0000_0000 : vcnt_r + 32'h0000_0001;

	always_ff @(posedge vid_clk_i) begin
		if (vrst_s) begin
			vcnt_r <= 32'h0000_0000;
		end else begin
			vcnt_r <= vcnt_nxt;
		end
	end

	always_ff @(posedge vid_clk_i) begin
		if (vrst_s) begin
			vhold_r    <= 32'h0000_0000;
			vack_tgl_r <= 1'b0;
		end else begin
			vhold_r    <= vcap ? vcnt_r : vhold_r;
			vack_tgl_r <= vreq_s;
		end
	end

endmodule : vcm_meter

`default_nettype wire

// *** dv/vcm_meter_asserts.sv ***
// Port-level assertions for the video clock frequency meter.
// Assumes the classic Wishbone timing of the meter: ack one cycle after a request is taken.
`timescale 1ns/1ps
`default_nettype none
module vcm_meter_asserts
	import vcm_pkg::*;
(
	input wire logic              clk_i,      // Bus clock.
	input wire logic              rst_i,      // Reset.
	input wire logic              vid_clk_i,  // Video clock.
	input wire logic              wb_cyc_i,   // Cycle.
	input wire logic              wb_stb_i,   // Strobe.
	input wire logic              wb_we_i,    // Write.
	input wire logic [VCM_AW-1:0] wb_adr_i,   // Address.
	input wire logic [3:0]        wb_sel_i,   // Byte enables.
	input wire logic [VCM_DW-1:0] wb_dat_i,   // Write data.
	input wire logic [VCM_DW-1:0] wb_dat_o,   // Read data.
	input wire logic              wb_ack_o    // Acknowledge.
);
	// *****
	// Shadow of the enable bit, so reads of it can be judged.
	// *****
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire  take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire  rd   = take && !wb_we_i;
	logic en_r;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			en_r <= 1'b0;
		else if (take && wb_we_i && wb_adr_i == VCM_ADR_CTRL && wb_sel_i[0])
			en_r <= wb_dat_i[0];
	end
	AST_ACK_NEXT: assert property (take |=> wb_ack_o) else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(take)) else $error("ack stray");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("data idle");
	AST_UNMAPPED: assert property (rd && wb_adr_i > VCM_ADR_STATUS |=> wb_dat_o == VCM_UNMAPPED_DATA)
		else $error("unmapped data");
	AST_STAT_EN: assert property (rd && wb_adr_i == VCM_ADR_STATUS |=>
		wb_dat_o[31:4] == '0 && wb_dat_o[0] == en_r) else $error("status bad");
	AST_CTRL_EN: assert property (rd && wb_adr_i == VCM_ADR_CTRL |=> wb_dat_o[0] == en_r)
		else $error("enable bad");
	AST_RST_QUIET: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o) else $error("ack in reset");
	cover property (take && wb_we_i);
	cover property (wb_ack_o && wb_dat_o != '0);
	cover property (rd && wb_adr_i > VCM_ADR_STATUS);
endmodule : vcm_meter_asserts
bind vcm_meter vcm_meter_asserts u_chk (.clk_i, .rst_i, .vid_clk_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

// *** dv/vcm_vid_src.sv ***
// Video clock source standing at the far side of the meter.
// Assumes the bench sets the half period in ps; the clock stands low while stopped.
`timescale 1ns/1ps
`default_nettype none
module vcm_vid_src (
	input  wire logic        run_i,      // Clock allowed.
	input  wire logic [15:0] half_ps_i,  // Half period in ps.
	output var  logic        vid_clk_o   // Video clock.
);
	initial begin
		vid_clk_o = 1'b0;
		forever begin
			#(half_ps_i / 1000.0);
			vid_clk_o = run_i ? ~vid_clk_o : 1'b0;
		end
	end
endmodule : vcm_vid_src
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench of the video clock frequency meter.
// Assumes a short window parameter of 64 cycles; counts are judged within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import vcm_pkg::*;
	logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, vrun = 1, ack, vclk;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'hF, bsel = 4'hF;
	logic [31:0] wdat = 32'h0, q, q1, dat_o;
	logic [15:0] vhp = 16'h4E20;
	int          num_errors = 0, total_checks = 0, n, e, m_dur, m_cnt;
	int          m_q[$];
	int          H[3] = '{20000, 6667, 3367};
	logic [7:0]  A[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	logic [31:0] E[5] = '{32'h0, 32'h40, 32'h0, 32'h0, 32'h0};
	vcm_vid_src src (.run_i(vrun), .half_ps_i(vhp), .vid_clk_o(vclk));
	vcm_meter #(.DURATION_RST(32'h40)) dut (.clk_i(clk), .rst_i(rst), .vid_clk_i(vclk), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack));
	initial forever #2.5 clk = ~clk;
	task chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk
	// Only the watchdog ends a wait for the acknowledge.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, bsel};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_o;
		{cyc, stb, we} <= 3'b000;
	endtask : wb
	// One window of N bus cycles of 5000 ps against a video period of 2*H ps; the clear at
	// each capture loses one video cycle.
	function automatic int model_count(input int nc, input int hp);
		return nc * 2500 / hp - 1;
	endfunction : model_count
	task give_verdict;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	initial begin
		n = $urandom(57);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			wb(0, A[i], 0);
			chk(q, E[i]);
		end
		$display("test reset done");
		wb(1, 8'h08, $urandom);
		wb(0, 8'h08, 0);
		chk(q, 32'h0);
		repeat (200) @(posedge clk);
		wb(0, 8'h08, 0);
		chk(q, 32'h0);
		wb(0, 8'h0C, 0);
		chk(q, 32'h0);
		m_dur = 'h40;
		e = $urandom;
		bsel = 4'h2;
		wb(1, 8'h04, e);
		bsel = 4'hF;
		m_dur = (m_dur & 32'hFFFF_00FF) | (e & 32'h0000_FF00);
		wb(0, 8'h04, 0);
		chk(q, m_dur);
		$display("test idle done");
		// Window lengths are random, so the expected count comes from the model.
		for (int i = 0; i < 3; i++) begin
			n = 100 + $urandom % 100;
			wb(1, 8'h04, n);
			wb(0, 8'h04, 0);
			chk(q, n);
			vhp <= 16'(H[i]);
			wb(1, 8'h00, 1);
			m_q.push_back(model_count(n, H[i]));
			repeat (3 * n + 40) @(posedge clk);
			wb(0, 8'h08, 0);
			m_cnt = m_q.pop_front();
			e = int'(q) - m_cnt;
			chk(q, (e <= 3 && e >= -3) ? q : 32'(m_cnt));
			wb(0, 8'h0C, 0);
			chk(q[3:0], 4'h3);
			wb(1, 8'h00, 0);
			repeat (40) @(posedge clk);
			wb(0, 8'h08, 0);
			q1 = q;
			wb(1, 8'h0C, 32'h2);
			repeat (n + 10) @(posedge clk);
			wb(0, 8'h08, 0);
			chk(q, q1);
			wb(0, 8'h0C, 0);
			chk(q, 32'h0);
			$display("test format %0d done", i);
		end
		wb(1, 8'h04, 100);
		wb(1, 8'h00, 1);
		vrun <= 1'b0;
		repeat (400) @(posedge clk);
		wb(0, 8'h08, 0);
		chk(q, 32'h0);
		wb(0, 8'h0C, 0);
		chk(q, 32'hD);
		$display("test stopped clock done");
		give_verdict();
	end
	initial begin
		#100us;
		num_errors++;
		give_verdict();
	end
endmodule : tb
`default_nettype wire
